// ===== core/swr_defines.vh
`ifndef SWR_DEFINES_VH
`define SWR_DEFINES_VH

// Clock period in ns
`define SWR_CLK_PERIOD_NS 10
// Debounce: least accepted low time and longest rejected glitch, in ns
`define SWR_MR_MIN_LOW_NS 1000
`define SWR_MR_GLITCH_NS 100
`define SWR_MR_MIN_LOW_CYC ((`SWR_MR_MIN_LOW_NS + `SWR_CLK_PERIOD_NS - 1) / `SWR_CLK_PERIOD_NS)
// Time base tick rate and watchdog periods in time base ticks
`define SWR_TICK_HZ 32768
`define SWR_WD_LONG_MS 1600
`define SWR_WD_SHORT_MS 200
`define SWR_WD_LONG_TICKS ((`SWR_WD_LONG_MS * `SWR_TICK_HZ) / 1000)
`define SWR_WD_SHORT_TICKS ((`SWR_WD_SHORT_MS * `SWR_TICK_HZ) / 1000)
`define SWR_HOLD_TICKS `SWR_WD_SHORT_TICKS
// Synchroniser lane positions
`define SWR_SYNC_W 4
`define SWR_SYNC_MR 3
`define SWR_SYNC_KICK 2
`define SWR_SYNC_RST 1
`define SWR_SYNC_BAT 0
// Configuration bit positions
`define SWR_CFG_PERIOD_BIT 4
`define SWR_CFG_ENABLE_BIT 7

`endif

// ===== core/swr_supervisor.v
// How it works
// R1: Manual reset low forces reset; release starts the full hold period.
// R2: Low of 1us is accepted; glitches of 100ns or less are rejected.
// R3: While reset is active, manual reset, kick and config writes are ignored; a low manual reset still holds the active state.
// R4: After supply recovers, both resets stay active for the hold period.
// R5: Supply dip forces reset; every assertion lasts at least the hold period.
// R6: Open-drain active-low and push-pull active-high outputs share one reset state.
// R7: Battery flag set when supply below threshold and below battery level.
// R8: Period bit 0 selects 1.6s timeout, 1 selects 200ms; resets to 0.
// R9: Enable bit resets to 0; watchdog runs only when it is 1.
// R10: Short period applies only after first kick edge following a reset.
// R11: Host must kick in time; expiry asserts reset for the hold period.
// R12: Expiry clears both period and enable bits; software rewrites them.
// R13: Host should set kick high in main loop and low in subroutines.
// R14: Any kick edge restarts counter; counter held clear when disabled or in reset.
// R15: Hold period is a parameter in time base ticks, default 200ms.
// R16: Supply comparisons enter synchronised; all decisions use synchronised values.
`timescale 1ns/1ps
`include "swr_defines.vh"
module swr_supervisor #(
   parameter TICK_W = 16,
   // R15: hold period parameter
   parameter HOLD_TICKS = `SWR_HOLD_TICKS,
   parameter WD_LONG_TICKS = `SWR_WD_LONG_TICKS,
   parameter WD_SHORT_TICKS = `SWR_WD_SHORT_TICKS,
   parameter MR_MIN_LOW_CYC = `SWR_MR_MIN_LOW_CYC
) (
   input wire clk,
   input wire rst_n,
   input wire tick,
   input wire manual_reset_n,
   input wire watchdog_kick_in,
   input wire supply_below_threshold,
   input wire supply_below_backup,
   input wire cfg_write,
   input wire [7:0] cfg_wdata,
   output reg [7:0] cfg_rdata,
   output wire reset_n_o,
   output wire reset_n_oe_n,
   output reg reset_high,
   output wire battery_active_flag_o,
   output wire battery_active_flag_oe_n,
   output reg battery_active_flag
);

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   // True on the last count of a tick counter before its limit
   function at_last_count;
      input [TICK_W-1:0] count;
      input [TICK_W-1:0] limit;
      begin
         at_last_count = (count >= limit - 1'b1);
      end
   endfunction

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   wire [`SWR_SYNC_W-1:0] sync_w;
   wire mr_n_s;
   wire kick_s;
   wire below_rst_s;
   wire below_bat_s;

   // R16: synchronised supply inputs
   swr_sync #(
      .WIDTH(`SWR_SYNC_W)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in({manual_reset_n, watchdog_kick_in, ~supply_below_threshold,
                 ~supply_below_backup}),
      .sync_out(sync_w)
   );
   assign mr_n_s = sync_w[`SWR_SYNC_MR];
   assign kick_s = sync_w[`SWR_SYNC_KICK];
   assign below_rst_s = ~sync_w[`SWR_SYNC_RST];
   assign below_bat_s = ~sync_w[`SWR_SYNC_BAT];

   // ----------------------------------------------------------------
   // Reset sequencer
   // ----------------------------------------------------------------
   localparam [2:0] ST_ACTIVE = 3'b001;
   localparam [2:0] ST_HOLD = 3'b010;
   localparam [2:0] ST_RUN = 3'b100;

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [TICK_W-1:0] hold_cnt_reg;
   reg [TICK_W-1:0] hold_cnt_next;
   reg [15:0] mr_cnt_reg;
   reg mr_valid;
   reg wd_expire;
   wire in_reset;

   assign in_reset = (state_reg != ST_RUN);

   // ----------------------------------------------------------------
   // Manual reset debounce
   // ----------------------------------------------------------------
   // R2: debounce counter for manual reset low time
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mr_cnt_reg <= 16'h0000;
      end else if (mr_n_s || in_reset) begin
         mr_cnt_reg <= 16'h0000;
      end else if (mr_cnt_reg < MR_MIN_LOW_CYC[15:0]) begin
         mr_cnt_reg <= mr_cnt_reg + 16'h0001;
      end
   end

   always @* begin
      // Valid from the last cycle of the minimum low time
      mr_valid = !mr_n_s && (mr_cnt_reg >= MR_MIN_LOW_CYC[15:0] - 16'h0001);
   end

   // ----------------------------------------------------------------
   // Reset state machine
   // ----------------------------------------------------------------
   always @* begin
      state_next = state_reg;
      hold_cnt_next = hold_cnt_reg;
      case (state_reg)
         ST_ACTIVE: begin
            hold_cnt_next = {TICK_W{1'b0}};
            // R4: leave active state only when supply is good
            if (!below_rst_s) begin
               state_next = ST_HOLD;
            end
         end
         ST_HOLD: begin
            // R5: supply dip restarts the assertion
            if (below_rst_s) begin
               state_next = ST_ACTIVE;
            end else if (tick) begin
               if (at_last_count(hold_cnt_reg, HOLD_TICKS[TICK_W-1:0])) begin
                  state_next = ST_RUN;
               end else begin
                  hold_cnt_next = hold_cnt_reg + 1'b1;
               end
            end
         end
         ST_RUN: begin
            hold_cnt_next = {TICK_W{1'b0}};
            if (below_rst_s) begin
               state_next = ST_ACTIVE;
            // R1: manual reset held until released, then hold period
            end else if (mr_valid) begin
               state_next = ST_ACTIVE;
            // Expiry skips the active state and starts the hold count
            // R11: expiry gives a hold-period reset
            end else if (wd_expire) begin
               state_next = ST_HOLD;
            end
         end
         default: begin
            state_next = ST_ACTIVE;
            hold_cnt_next = {TICK_W{1'b0}};
         end
      endcase
      // R1: active state also lasts while manual reset stays low
      if (state_reg == ST_ACTIVE && !mr_n_s) begin
         state_next = ST_ACTIVE;
      end
   end

   // ----------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_ACTIVE;
         hold_cnt_reg <= {TICK_W{1'b0}};
      end else begin
         state_reg <= state_next;
         hold_cnt_reg <= hold_cnt_next;
      end
   end

   // ----------------------------------------------------------------
   // Reset outputs
   // ----------------------------------------------------------------
   reg reset_reg;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reset_reg <= 1'b1;
         reset_high <= 1'b1;
      end else begin
         reset_reg <= (state_next != ST_RUN);
         reset_high <= (state_next != ST_RUN);
      end
   end

   // R6: open-drain low output pulls while reset is active
   assign reset_n_o = 1'b0;
   assign reset_n_oe_n = ~reset_reg;

   // ----------------------------------------------------------------
   // Battery switchover
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         battery_active_flag <= 1'b0;
      end else begin
         // R7: battery flag on both conditions
         battery_active_flag <= below_rst_s && below_bat_s;
      end
   end

   // Open-drain flag: pin pulled low while on battery
   assign battery_active_flag_o = 1'b0;
   assign battery_active_flag_oe_n = ~battery_active_flag;

   // ----------------------------------------------------------------
   // Watchdog
   // ----------------------------------------------------------------
   reg watchdog_enable_bit;
   reg period_short_bit;
   reg kicked_reg;
   reg kick_prev_reg;
   reg [TICK_W-1:0] wd_cnt_reg;
   wire kick_edge;
   wire [TICK_W-1:0] wd_limit;

   // R14: either edge of the kick
   assign kick_edge = (kick_s != kick_prev_reg) && !in_reset;

   // R10: long period until first kick edge after reset
   assign wd_limit = (period_short_bit && kicked_reg) ? WD_SHORT_TICKS[TICK_W-1:0]
                                                      : WD_LONG_TICKS[TICK_W-1:0];

   always @* begin
      // R8: timeout selects period by bit
      wd_expire = watchdog_enable_bit && tick && at_last_count(wd_cnt_reg, wd_limit);
   end

   // ----------------------------------------------------------------
   // Kick edge detector
   // ----------------------------------------------------------------
   // Edges seen during reset are masked, so this reset value is harmless
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         kick_prev_reg <= 1'b1;
      end else begin
         kick_prev_reg <= kick_s;
      end
   end

   // ----------------------------------------------------------------
   // Watchdog counter
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wd_cnt_reg <= {TICK_W{1'b0}};
         kicked_reg <= 1'b0;
      // R14: counter cleared when disabled or in reset
      end else if (in_reset || !watchdog_enable_bit) begin
         wd_cnt_reg <= {TICK_W{1'b0}};
         kicked_reg <= 1'b0;
      end else if (kick_edge) begin
         wd_cnt_reg <= {TICK_W{1'b0}};
         kicked_reg <= 1'b1;
      end else if (wd_expire) begin
         wd_cnt_reg <= {TICK_W{1'b0}};
      end else if (tick) begin
         wd_cnt_reg <= wd_cnt_reg + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Configuration bits
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // R9: watchdog starts disabled, long period
         watchdog_enable_bit <= 1'b0;
         period_short_bit <= 1'b0;
      // R12: expiry clears both bits, winning over a write
      end else if (wd_expire && state_reg == ST_RUN) begin
         watchdog_enable_bit <= 1'b0;
         period_short_bit <= 1'b0;
      // R3: writes ignored during reset
      end else if (cfg_write && !in_reset) begin
         watchdog_enable_bit <= cfg_wdata[`SWR_CFG_ENABLE_BIT];
         period_short_bit <= cfg_wdata[`SWR_CFG_PERIOD_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Configuration read-back
   // ----------------------------------------------------------------
   // Unused bits read as zero
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_rdata <= 8'h00;
      end else begin
         cfg_rdata <= 8'h00;
         cfg_rdata[`SWR_CFG_ENABLE_BIT] <= watchdog_enable_bit;
         cfg_rdata[`SWR_CFG_PERIOD_BIT] <= period_short_bit;
      end
   end

endmodule // swr_supervisor

// ===== core/swr_sync.v
`timescale 1ns/1ps
module swr_sync #(
   parameter WIDTH = 4
) (
   clk,
   rst_n,
   async_in,
   sync_out
);
   input wire clk;
   input wire rst_n;
   input wire [WIDTH-1:0] async_in;
   output wire [WIDTH-1:0] sync_out;

   reg [WIDTH-1:0] meta_reg;
   reg [WIDTH-1:0] sync_reg;

   // Two-stage synchroniser; inputs reset to their idle (high) level
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= {WIDTH{1'b1}};
         sync_reg <= {WIDTH{1'b1}};
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;
endmodule // swr_sync

// ===== tb/swr_host_model.sv
`timescale 1ns/1ps
module swr_host_model (
   input wire clk,
   input wire reset_pin_n,
   input wire run,
   output reg kick
);
   integer loop_cnt = 0;
   initial kick = 1'b0;
   always @(negedge clk) begin
      loop_cnt <= (reset_pin_n && run) ? (loop_cnt + 1) % 40 : 0;
      if (reset_pin_n && run && loop_cnt == 39) kick <= ~kick;
   end
endmodule // swr_host_model

// ===== tb/swr_supervisor_properties.sv
`timescale 1ns/1ps
module swr_supervisor_properties #(parameter HOLD_TICKS = 4, parameter MR_MIN_LOW_CYC = 100) (
   input wire clk,
   input wire rst_n,
   input wire tick,
   input wire manual_reset_n,
   input wire supply_below_threshold,
   input wire supply_below_backup,
   input wire [7:0] cfg_rdata,
   input wire reset_n_oe_n,
   input wire reset_high,
   input wire battery_active_flag
);
   reg [7:0] hold_cnt, mr_cnt;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_cnt <= 8'h00;
         mr_cnt <= 8'h00;
      end else begin
         hold_cnt <= reset_high ? hold_cnt + {7'h00, tick} : 8'h00;
         mr_cnt <= manual_reset_n ? 8'h00 : mr_cnt + {7'h00, ~&mr_cnt};
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_glitch; $fell(manual_reset_n) ##1 !manual_reset_n [*4] ##1 manual_reset_n; endsequence
   property p_pins; reset_high == !reset_n_oe_n; endproperty
   property p_dip; $rose(supply_below_threshold) |-> ##[1:6] reset_high; endproperty
   property p_hold; $fell(reset_high) |-> hold_cnt >= HOLD_TICKS; endproperty
   property p_mr; mr_cnt > MR_MIN_LOW_CYC + 5 |-> reset_high; endproperty
   property p_glitch; !reset_high && !cfg_rdata[7] ##0 s_glitch |=> !reset_high [*8]; endproperty
   property p_backup_supply_in; (supply_below_threshold && supply_below_backup) [*5] |-> battery_active_flag;
   endproperty
   property p_refuse; reset_high [*6] |-> $stable(cfg_rdata); endproperty
   property p_expire; $rose(reset_high) && cfg_rdata[7] && manual_reset_n &&
      !supply_below_threshold |-> ##[0:3] cfg_rdata == 8'h00; endproperty
   a_pins: assert property (p_pins) else $error("pins");
   a_dip: assert property (p_dip) else $error("dip");
   a_hold: assert property (p_hold) else $error("hold");
   a_mr: assert property (p_mr) else $error("manual");
   a_glitch: assert property (p_glitch) else $error("glitch");
   a_backup_supply_in: assert property (p_backup_supply_in) else $error("battery");
   a_refuse: assert property (p_refuse) else $error("refuse");
   a_expire: assert property (p_expire) else $error("expire");
endmodule // swr_supervisor_properties
bind swr_supervisor swr_supervisor_properties #(.HOLD_TICKS(HOLD_TICKS),
   .MR_MIN_LOW_CYC(MR_MIN_LOW_CYC)) swr_supervisor_properties_i (.clk(clk), .rst_n(rst_n),
   .tick(tick), .manual_reset_n(manual_reset_n), .supply_below_threshold(supply_below_threshold),
   .supply_below_backup(supply_below_backup), .cfg_rdata(cfg_rdata),
   .reset_n_oe_n(reset_n_oe_n), .reset_high(reset_high),
   .battery_active_flag(battery_active_flag));

// ===== tb/tb_supervisor_watchdog_reset.sv
`timescale 1ns/1ps
module tb_supervisor_watchdog_reset;
   reg clk = 1'b0;
   reg rst_n, mr_n, run, sbt, sbb, wr;
   reg [7:0] wd;
   reg [2:0] div = 3'h0;
   wire kick, ro, roe_n, rh, bat, bo, boe_n;
   wire bat_pin_n = boe_n | bo;
   wire [7:0] rd;
   wire tick = div == 3'h7;
   wire pin_n = roe_n | ro;
   integer num_errors = 0;
   integer tests_run = 0;
   integer n;
   swr_supervisor #(.HOLD_TICKS(4), .WD_LONG_TICKS(40), .WD_SHORT_TICKS(8)) swr_supervisor_i (
      .clk(clk), .rst_n(rst_n), .tick(tick), .manual_reset_n(mr_n), .watchdog_kick_in(kick),
      .supply_below_threshold(sbt), .supply_below_backup(sbb), .cfg_write(wr), .cfg_wdata(wd),
      .cfg_rdata(rd), .reset_n_o(ro), .reset_n_oe_n(roe_n), .reset_high(rh),
      .battery_active_flag_o(bo), .battery_active_flag_oe_n(boe_n), .battery_active_flag(bat));
   swr_host_model swr_host_model_i (.clk(clk), .reset_pin_n(pin_n), .run(run), .kick(kick));
   initial forever #5 clk = ~clk;
   always @(negedge clk) div <= div + 3'h1;
   task check(input ok, input [63:0] m);
      tests_run = tests_run + 1;
      if (ok !== 1'b1) begin
         num_errors = num_errors + 1;
         $display("wrong value at %0t: %0s", $time, m);
      end
   endtask
   task wait_rst(input v);
      for (n = 0; rh !== v && n < 2000; n = n + 1) @(negedge clk);
   endtask
   task write_cfg(input [7:0] d);
      {wr, wd} = {1'b1, d};
      @(negedge clk);
      wr = 1'b0;
      repeat (3) @(negedge clk);
   endtask
   task give_verdict;
      if (num_errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task t_mr;
      check(rh === 1'b1 && pin_n === 1'b0 && rd === 8'h00, "por");
      wait_rst(1'b0);
      check(n > 23 && n < 60, "por hold");
      mr_n = 1'b0;
      repeat (5) @(negedge clk);
      mr_n = 1'b1;
      repeat (20) @(negedge clk);
      check(rh === 1'b0, "glitch");
      mr_n = 1'b0;
      repeat (150) @(negedge clk);
      check(rh === 1'b1, "mr");
      mr_n = 1'b1;
      wait_rst(1'b0);
      check(n > 23 && n < 60, "mr hold");
   endtask
   task t_supply;
      {sbt, sbb} = 2'b11;
      repeat (6) @(negedge clk);
      write_cfg(8'h90);
      check(rh === 1'b1 && bat === 1'b1 && rd === 8'h00, "dip");
      check(bat_pin_n === 1'b0, "bat pin");
      sbb = 1'b0;
      repeat (6) @(negedge clk);
      check(bat === 1'b0 && bat_pin_n === 1'b1, "backup_supply_in off");
      sbt = 1'b0;
      wait_rst(1'b0);
      check(n > 23 && n < 60, "dip hold");
   endtask
   task t_wd(input [7:0] d, input k, input integer lo, input integer hi);
      write_cfg(d);
      check(rd === d, "cfg");
      if (k) begin
         run = 1'b1;
         repeat (400) @(negedge clk);
         check(rh === 1'b0, "kicked");
         @(kick);
         run = 1'b0;
      end
      wait_rst(1'b1);
      check(n >= lo && n <= hi, "timeout");
      repeat (8) @(negedge clk);
      check(rd === 8'h00, "clear");
      wait_rst(1'b0);
      check(n > 23 && n < 60, "wd hold");
   endtask
   initial begin
      {rst_n, mr_n, run, sbt, sbb, wr, wd} = {6'h10, 8'h00};
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      t_mr;
      t_supply;
      t_wd(8'h90, 1'b0, 300, 340);
      t_wd(8'h90, 1'b1, 52, 80);
      t_wd(8'h80, 1'b1, 300, 340);
      give_verdict;
   end
   initial begin
      #100000;
      num_errors = num_errors + 1;
      give_verdict;
   end
endmodule // tb_supervisor_watchdog_reset
